// *** hdl/ltq_regs.sv ***
// load torque and microstep table register bank behind an apb slave
`timescale 1ns/10ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module ltq_regs #(
	parameter int unsigned LEARN_STEPS = ltq_pkg::LEARN_STEPS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ltq_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [ltq_pkg::METRIC_W-1:0] load_sample,
	input wire logic load_sample_valid,
	output logic [7:0] table_entry7_current,
	output logic [7:0] table_entry8_current,
	output logic table_active,
	output logic [ltq_pkg::METRIC_W-1:0] learn_const_start,
	output logic [ltq_pkg::METRIC_W-1:0] learn_const_final,
	output logic [7:0] learn_current,
	output logic learning_busy,
	output logic [7:0] band_upper_limit,
	output logic [7:0] band_lower_limit,
	output logic [ltq_pkg::METRIC_W-1:0] load_metric
);
	import ltq_pkg::*;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
		return a == {idx, 2'b00};
	endfunction

	logic hit_e7;
	logic hit_e8;
	logic hit_mlo;
	logic hit_mhi;
	logic hit_l1lo;
	logic hit_lvl;
	logic hit_l2lo;
	logic hit_bup;
	logic hit_blo;
	logic hit_ctrl;
	logic mapped;
	logic setup_ph;
	logic wr_acc;

	assign hit_e7 = reg_hit(paddr, IDX_ENTRY7);
	assign hit_e8 = reg_hit(paddr, IDX_ENTRY8);
	assign hit_mlo = reg_hit(paddr, IDX_METRIC_LO);
	assign hit_mhi = reg_hit(paddr, IDX_METRIC_HI);
	assign hit_l1lo = reg_hit(paddr, IDX_LEARN1_LO);
	assign hit_lvl = reg_hit(paddr, IDX_LEVEL);
	assign hit_l2lo = reg_hit(paddr, IDX_LEARN2_LO);
	assign hit_bup = reg_hit(paddr, IDX_BAND_UP);
	assign hit_blo = reg_hit(paddr, IDX_BAND_LO);
	assign hit_ctrl = reg_hit(paddr, IDX_CTRL);
	assign mapped = hit_e7 | hit_e8 | hit_mlo | hit_mhi | hit_l1lo | hit_lvl
		| hit_l2lo | hit_bup | hit_blo | hit_ctrl;
	assign setup_ph = psel & ~penable;
	// data lives in byte lane zero, so only that strobe matters
	assign wr_acc = psel & penable & pwrite & pready & pstrb[0];

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [7:0] entry7_q;
	logic [7:0] entry8_q;
	logic [2:0] l1_hi_q;
	logic [1:0] rsvd_q;
	logic [7:0] l1_lo_q;
	logic [LEVEL_W-1:0] level_q;
	logic [2:0] l2_hi_q;
	logic [7:0] l2_lo_q;
	logic [7:0] bup_q;
	logic [7:0] blo_q;
	logic table_en_q;
	logic trig_q;
	logic trig_d;
	logic [7:0] ap7_q;
	logic [7:0] ap8_q;
	logic act_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [7:0] rd_byte;
	logic [7:0] reg_lvl;
	logic [7:0] reg_ctrl;
	logic trig_wr1;
	logic learn_start;
	logic learn_done;
	logic [METRIC_W-1:0] metric;

	assign reg_lvl = {level_q, l2_hi_q};
	assign reg_ctrl = {6'h00, trig_q, table_en_q};
	assign trig_wr1 = wr_acc & hit_ctrl & pwdata[CTRL_LEARN_BIT];
	// a trigger while learning runs is absorbed; one on the finishing cycle
	// restarts it, so a set that wins over the clear never leaves the bit stuck
	assign learn_start = trig_wr1 & (learn_done | (~trig_q & ~learning_busy));

	// set wins over the hardware clear
	assign trig_d = trig_wr1 ? 1'b1 : (learn_done ? 1'b0 : trig_q);

	// register read mux, reads have no side effect
	assign rd_byte = hit_e7 ? entry7_q :
		hit_e8 ? entry8_q :
		hit_mlo ? metric[7:0] :
		hit_mhi ? {metric[METRIC_W-1:8], rsvd_q, l1_hi_q} :
		hit_l1lo ? l1_lo_q :
		hit_lvl ? reg_lvl :
		hit_l2lo ? l2_lo_q :
		hit_bup ? bup_q :
		hit_blo ? blo_q :
		hit_ctrl ? reg_ctrl : 8'h00;

	// ----------------------------------------------------------------
	// apb answer, zero wait states
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= 1'b1;
			pslverr_q <= setup_ph & ~mapped;
			if (setup_ph) begin
				prdata_q <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
			end
		end
	end

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			entry7_q <= RST_BYTE;
			entry8_q <= RST_BYTE;
			bup_q <= RST_BYTE;
			blo_q <= RST_BYTE;
		end else begin
			if (wr_acc & hit_e7) entry7_q <= pwdata[7:0];
			if (wr_acc & hit_e8) entry8_q <= pwdata[7:0];
			if (wr_acc & hit_bup) bup_q <= pwdata[7:0];
			if (wr_acc & hit_blo) blo_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{l1_hi_q, rsvd_q} <= 5'h00;
			l1_lo_q <= RST_BYTE;
			{level_q, l2_hi_q} <= RST_LEVEL_REG;
			l2_lo_q <= RST_BYTE;
		end else begin
			// start constant halves; metric bits 7:5 dropped
			if (wr_acc & hit_mhi) begin
				l1_hi_q <= pwdata[2:0];
				rsvd_q <= pwdata[METRIC_HI_LSB-1:RSVD_LSB];
			end
			if (wr_acc & hit_l1lo) l1_lo_q <= pwdata[7:0];
			if (wr_acc & hit_lvl) {level_q, l2_hi_q} <= pwdata[7:0];
			if (wr_acc & hit_l2lo) l2_lo_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_en_q <= 1'b0;
			trig_q <= 1'b0;
			ap7_q <= RST_BYTE;
			ap8_q <= RST_BYTE;
			act_q <= 1'b0;
		end else begin
			if (wr_acc & hit_ctrl) table_en_q <= pwdata[CTRL_TABLE_BIT];
			trig_q <= trig_d;
			ap7_q <= table_en_q ? entry7_q : 8'h00;
			ap8_q <= table_en_q ? entry8_q : 8'h00;
			act_q <= table_en_q;
		end
	end

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	ltq_load_meter u_meter (
		.pclk(pclk),
		.presetn(presetn),
		.sample(load_sample),
		.sample_valid(load_sample_valid),
		.metric(metric)
	);

	ltq_learn_seq #(
		.STEPS(LEARN_STEPS),
		.STEP_CYC(LEARN_STEP_CYC)
	) u_learn (
		.pclk(pclk),
		.presetn(presetn),
		.start(learn_start),
		.start_level(level_q),
		.current(learn_current),
		.busy(learning_busy),
		.done(learn_done)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign table_entry7_current = ap7_q;
	assign table_entry8_current = ap8_q;
	assign table_active = act_q;
	assign learn_const_start = {l1_hi_q, l1_lo_q};
	assign learn_const_final = {l2_hi_q, l2_lo_q};
	assign band_upper_limit = bup_q;
	assign band_lower_limit = blo_q;
	assign load_metric = metric;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_entry7_store: assert property (
		wr_acc && hit_e7 |=> entry7_q == $past(pwdata[7:0]))
		else $error("entry seven did not take the written byte");

	a_entry8_read: assert property (
		setup_ph && !pwrite && hit_e8 |=> prdata_q == {24'h000000, $past(entry8_q)})
		else $error("entry eight read returned a wrong value");

	a_metric_low: assert property (
		setup_ph && !pwrite && hit_mlo |=> prdata_q[7:0] == $past(metric[7:0]) && !pslverr_q)
		else $error("metric low byte read wrong");

	a_metric_high: assert property (
		setup_ph && !pwrite && hit_mhi
		|=> prdata_q[7:5] == $past(metric[10:8])
		&& prdata_q[4:0] == $past({rsvd_q, l1_hi_q}))
		else $error("metric high bits were writable or constant bits lost");

	a_learn_const: assert property (
		wr_acc && hit_l1lo |=> learn_const_start[7:0] == $past(pwdata[7:0])
		&& learn_const_start[10:8] == $past(l1_hi_q))
		else $error("start learning constant not assembled from its two halves");

	a_final_const: assert property (
		wr_acc && hit_lvl |=> learn_const_final[10:8] == $past(pwdata[2:0])
		&& level_q == $past(pwdata[7:LEVEL_LSB]))
		else $error("final constant top bits or level not stored");

	a_band_hold: assert property (
		!(wr_acc && hit_bup) |=> band_upper_limit == $past(bup_q))
		else $error("band upper limit changed without a write");

	a_band_lower: assert property (
		wr_acc && hit_blo |=> band_lower_limit == $past(pwdata[7:0]))
		else $error("band lower limit did not take the written byte");

	a_trig_start: assert property (
		learn_start |=> trig_q ##1 learning_busy)
		else $error("learning trigger did not start learning");

	a_trig_clear: assert property (
		learn_done && !trig_wr1 |=> !trig_q)
		else $error("learning trigger not cleared when learning ended");

	a_table_gate: assert property (
		!table_en_q ##1 !table_en_q |-> table_entry7_current == 8'h00
		&& table_entry8_current == 8'h00 && !table_active)
		else $error("table entries applied while the table is disabled");

	a_unmapped_err: assert property (
		setup_ph && !mapped |=> pslverr_q && pready_q && (pwrite || prdata_q == 32'h00000000))
		else $error("unmapped access not refused");

	c_learn_run: cover property (learn_start ##[1:1000] learn_done);
	c_table_on: cover property (table_active && table_entry7_current != 8'h00);
	c_metric_rd: cover property (setup_ph && !pwrite && hit_mhi && metric[10:8] != 3'h0);
endmodule

// *** hdl/ltq_pkg.sv ***
// constants shared by the load torque and microstep table register bank
package ltq_pkg;
	// ---------------------------------------------------------------
	// bus and register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned IDX_W = 10;
	localparam logic [9:0] IDX_ENTRY7 = 10'h01D;
	localparam logic [9:0] IDX_ENTRY8 = 10'h01E;
	localparam logic [9:0] IDX_METRIC_LO = 10'h01F;
	localparam logic [9:0] IDX_METRIC_HI = 10'h020;
	localparam logic [9:0] IDX_LEARN1_LO = 10'h021;
	localparam logic [9:0] IDX_LEVEL = 10'h022;
	localparam logic [9:0] IDX_LEARN2_LO = 10'h023;
	localparam logic [9:0] IDX_BAND_UP = 10'h024;
	localparam logic [9:0] IDX_BAND_LO = 10'h025;
	localparam logic [9:0] IDX_CTRL = 10'h040;
	// ---------------------------------------------------------------
	// field positions and widths
	// ---------------------------------------------------------------
	localparam int unsigned METRIC_W = 11;
	localparam int unsigned METRIC_HI_LSB = 5;
	localparam int unsigned RSVD_LSB = 3;
	localparam int unsigned LEVEL_LSB = 3;
	localparam int unsigned LEVEL_W = 5;
	localparam int unsigned LEVEL_SHIFT = 3;
	localparam int unsigned CTRL_TABLE_BIT = 0;
	localparam int unsigned CTRL_LEARN_BIT = 1;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_LEVEL_REG = 8'h20;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_NS = 20;
	localparam int unsigned LEARN_STEP_NS = 2000;
	localparam int unsigned LEARN_STEP_CYC = (LEARN_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned LEARN_STEPS = 16;
endpackage

// *** hdl/ltq_load_meter.sv ***
// load metric estimator: two-sample average of the torque samples
`timescale 1ns/10ps
module ltq_load_meter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ltq_pkg::METRIC_W-1:0] sample,
	input wire logic sample_valid,
	output logic [ltq_pkg::METRIC_W-1:0] metric
);
	import ltq_pkg::*;

	logic [METRIC_W-1:0] prev_q;
	logic [METRIC_W-1:0] metric_q;
	logic [METRIC_W:0] sum;

	// averaging keeps the metric linear in torque, one extra bit avoids overflow
	assign sum = {1'b0, prev_q} + {1'b0, sample};
	assign metric = metric_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
			metric_q <= '0;
		end else if (sample_valid) begin
			prev_q <= sample;
			metric_q <= sum[METRIC_W:1];
		end
	end

	a_meter_avg: assert property (@(posedge pclk) disable iff (!presetn)
		sample_valid ##1 sample_valid |=> metric_q == METRIC_W'(({1'b0, $past(sample, 2)}
		+ {1'b0, $past(sample)}) >> 1))
		else $error("load metric is not the average of the last two samples");
endmodule

// *** hdl/ltq_learn_seq.sv ***
// torque learning sequencer: ramps the learning current from its start level
`timescale 1ns/10ps
module ltq_learn_seq #(
	parameter int unsigned STEPS = ltq_pkg::LEARN_STEPS,
	parameter int unsigned STEP_CYC = ltq_pkg::LEARN_STEP_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [ltq_pkg::LEVEL_W-1:0] start_level,
	output logic [7:0] current,
	output logic busy,
	output logic done
);
	import ltq_pkg::*;

	typedef enum logic [1:0] {
		LTQ_IDLE = 2'b00,
		LTQ_RAMP = 2'b01,
		LTQ_FINISH = 2'b10
	} ltq_learn_t;

	ltq_learn_t state_q;
	ltq_learn_t state_d;
	logic [15:0] div_q;
	logic [7:0] step_q;
	logic [7:0] cur_q;
	logic busy_q;
	logic tick;
	logic last_step;
	logic can_start;

	// ----------------------------------------------------------------
	// step divider
	// ----------------------------------------------------------------
	assign tick = (state_q == LTQ_RAMP) && (div_q == 16'(STEP_CYC - 1));
	assign last_step = tick && (step_q == 8'(STEPS - 1));
	// a start on the finishing cycle chains straight into a new ramp
	assign can_start = start && (state_q == LTQ_IDLE || state_q == LTQ_FINISH);
	assign done = (state_q == LTQ_FINISH);
	assign current = cur_q;
	assign busy = busy_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			LTQ_IDLE: if (start) state_d = LTQ_RAMP;
			LTQ_RAMP: if (last_step) state_d = LTQ_FINISH;
			LTQ_FINISH: state_d = start ? LTQ_RAMP : LTQ_IDLE;
			default: state_d = LTQ_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= LTQ_IDLE;
			div_q <= 16'h0000;
			step_q <= 8'h00;
			cur_q <= 8'h00;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q <= (state_d != LTQ_IDLE);
			div_q <= (tick || state_q != LTQ_RAMP) ? 16'h0000 : div_q + 16'h0001;
			if (can_start) begin
				step_q <= 8'h00;
				// start current is level times eight
				cur_q <= {start_level, 3'b000};
			end else if (tick) begin
				step_q <= step_q + 8'h01;
				// saturate: the ramp never wraps back to a low current
				cur_q <= (cur_q == 8'hFF) ? cur_q : cur_q + 8'h01;
			end
		end
	end

	a_learn_level: assert property (@(posedge pclk) disable iff (!presetn)
		can_start |=> cur_q == {$past(start_level), 3'b000} && busy_q)
		else $error("learning current does not start at level times eight");
endmodule

// *** tb/ltq_regs_tb.sv ***
// self-checking bench for the load torque and microstep table register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module ltq_regs_tb;
	import ltq_pkg::*;
	// --------------------------------------------------------------
	// signals and model state
	// --------------------------------------------------------------
	localparam int unsigned STEPS = 2;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [METRIC_W-1:0] load_sample = '0;
	logic load_sample_valid = 1'b0;
	logic [7:0] t7, t8, lcur, bup, blo;
	logic tact, lbusy;
	logic [METRIC_W-1:0] lcs, lcf, lmet;
	int error_cnt = 0;
	int checks = 0;
	int mdl[int];
	int met = 0;
	int ctl = 0;
	int idxs[$] = '{'h1D, 'h1E, 'h1F, 'h20, 'h21, 'h22, 'h23, 'h24, 'h25, 'h40};
	logic [15:0] seed = 16'hD16D;
	logic [31:0] rdv;
	logic erv;
	int a, b, n;

	always #10 pclk = ~pclk;

	ltq_regs #(.LEARN_STEPS(STEPS)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .load_sample(load_sample),
		.load_sample_valid(load_sample_valid), .table_entry7_current(t7),
		.table_entry8_current(t8), .table_active(tact), .learn_const_start(lcs),
		.learn_const_final(lcf), .learn_current(lcur), .learning_busy(lbusy),
		.band_upper_limit(bup), .band_lower_limit(blo), .load_metric(lmet));

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// read-only metric bytes come from the model, not the stored copy
	function automatic int expv(input int idx);
		case (idx)
			'h1F: return met & 'hFF;
			'h20: return ((met >> 8) << 5) | (mdl[idx] & 'h1F);
			'h40: return ctl;
			default: return mdl.exists(idx) ? mdl[idx] : 0;
		endcase
	endfunction

	// idle edge first, so no strobe is driven twice in one time step
	task automatic apb(input logic wr, input int idx, input int d, input logic [3:0] st);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ADDR_W'(idx * 4);
		pwdata <= {24'h0, 8'(d)};
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait limit here: only the watchdog ends a hung transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input int idx, input int d);
		apb(1'b1, idx, d, 4'hF);
	endtask

	task automatic rchk(input int idx, input logic exp_err);
		apb(1'b0, idx, 0, 4'h0);
		`CHK($sformatf("read %0h", idx), exp_err ? 0 : expv(idx), rdv)
		`CHK($sformatf("error %0h", idx), exp_err, erv)
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// --------------------------------------------------------------
	// watchdog: whole sequence needs well under 5000 cycles
	// --------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		summarize();
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		foreach (idxs[i]) mdl[idxs[i]] = 0;
		mdl['h22] = 'h20;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (idxs[i]) rchk(idxs[i], 1'b0);
		`CHK("band upper at reset", 8'h00, bup)
		// random values into every writable byte except control at 0x40, then read back
		foreach (idxs[i]) begin
			if (idxs[i] != 'h1F && idxs[i] != 'h40) begin
				seed = lfsr(seed);
				wr(idxs[i], seed[7:0]);
				mdl[idxs[i]] = seed[7:0];
			end
		end
		foreach (idxs[i]) rchk(idxs[i], 1'b0);
		`CHK("start constant", 11'(((mdl['h20] & 7) << 8) | mdl['h21]), lcs)
		`CHK("final constant", 11'(((mdl['h22] & 7) << 8) | mdl['h23]), lcf)
		`CHK("band upper", 8'(mdl['h24]), bup)
		`CHK("band lower", 8'(mdl['h25]), blo)
		// refused writes: read-only byte, cleared strobe, unmapped offsets
		wr('h1F, 'hFF);
		apb(1'b1, 'h24, mdl['h24] ^ 'hFF, 4'h0);
		wr('h26, 'h55);
		rchk('h1F, 1'b0);
		rchk('h24, 1'b0);
		rchk('h26, 1'b1);
		rchk('h41, 1'b1);
		// back-to-back samples, metric is their two-sample average
		repeat (3) begin
			seed = lfsr(seed);
			a = seed[10:0];
			seed = lfsr(seed);
			b = seed[10:0];
			@(posedge pclk);
			load_sample <= 11'(a);
			load_sample_valid <= 1'b1;
			@(posedge pclk);
			load_sample <= 11'(b);
			@(posedge pclk);
			load_sample_valid <= 1'b0;
			@(posedge pclk);
			met = (a + b) >> 1;
			`CHK("load metric", 11'(met), lmet)
			rchk('h1F, 1'b0);
			rchk('h20, 1'b0);
			rchk('h1F, 1'b0);
		end
		// table output held at zero until the enable bit is set
		`CHK("entry7 disabled", 8'h00, t7)
		wr('h40, 1);
		ctl = 1;
		repeat (3) @(posedge pclk);
		`CHK("entry7 enabled", 8'(mdl['h1D]), t7)
		`CHK("entry8 enabled", 8'(mdl['h1E]), t8)
		`CHK("table active", 1'b1, tact)
		// learning from level 5, second trigger while busy is ignored
		mdl['h22] = (5 << 3) | (mdl['h22] & 7);
		wr('h22, mdl['h22]);
		wr('h40, 3);
		ctl = 3;
		n = 0;
		while (lbusy !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
		`CHK("learn busy", 1'b1, lbusy)
		`CHK("learn start current", 8'(5 * 8), lcur)
		wr('h40, 3);
		rchk('h40, 1'b0);
		n = 0;
		while (lbusy !== 1'b0 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		repeat (2) @(posedge pclk);
		`CHK("learn end current", 8'(5 * 8 + STEPS), lcur)
		ctl = 1;
		rchk('h40, 1'b0);
		wr('h40, 0);
		ctl = 0;
		repeat (3) @(posedge pclk);
		`CHK("entry8 disabled", 8'h00, t8)
		summarize();
	end
endmodule
